// ---- rtl/omm_pkg.sv ----
// Purpose: Shared constants and types for the output mute and margin control
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   Register indices are kept; byte address is four times the index
package omm_pkg;

  localparam int          NUM_CH          = 8;
  localparam int          NUM_DIV         = 6;
  localparam int          NUM_STAT        = 2;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;

  localparam logic [7:0]  IDX_CHAN_MUTE   = 8'h16;
  localparam logic [7:0]  IDX_STAT_MUTE   = 8'h17;
  localparam logic [7:0]  IDX_DIV_DLY     = 8'h18;
  localparam logic [7:0]  IDX_STATUS      = 8'h19;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_MUTE = ADDR_W'(IDX_CHAN_MUTE * 4);
  localparam logic [ADDR_W-1:0] ADDR_STAT_MUTE = ADDR_W'(IDX_STAT_MUTE * 4);
  localparam logic [ADDR_W-1:0] ADDR_DIV_DLY   = ADDR_W'(IDX_DIV_DLY * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = ADDR_W'(IDX_STATUS * 4);

  localparam logic [7:0]  RST_CHAN_MUTE   = 8'hFF;
  localparam logic [1:0]  RST_STAT_MUTE   = 2'h2;
  localparam logic [5:0]  RST_DIV_DLY     = 6'h00;
  localparam logic [7:0]  MARGIN_MIN_DIV  = 8'h08;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef struct packed {
    logic [NUM_CH-1:0]   chan_gate;
    logic [NUM_STAT-1:0] stat_gate;
  } omm_gate_t;

  typedef enum logic [1:0] {
    OMM_G_RUN  = 2'b00,
    OMM_G_WAIT = 2'b01,
    OMM_G_OFF  = 2'b10
  } omm_gstate_t;

endpackage : omm_pkg

// ---- rtl/omm_gate_cell.sv ----
// Purpose: One glitch-free output gate, switching only at a clock low phase
// Assumes: clk_low is a level from the clock domain, already synchronised
// Notes:   Gate changes only while the divided clock sits low
`timescale 1ns/1ps
module omm_gate_cell (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic want_off,
  input  wire logic clk_low,
  output logic      gate_off
);
  import omm_pkg::*;

  omm_gstate_t state_r;

  // Waiting for a low phase avoids cutting a high pulse short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= OMM_G_RUN;
    end else begin
      case (state_r)
        OMM_G_RUN:  if (want_off) state_r <= OMM_G_WAIT;
        OMM_G_WAIT: begin
          if (!want_off) state_r <= OMM_G_RUN;
          else if (clk_low) state_r <= OMM_G_OFF;
        end
        OMM_G_OFF:  if (!want_off && clk_low) state_r <= OMM_G_RUN;
        default:    state_r <= OMM_G_RUN;
      endcase
    end
  end

  assign gate_off = (state_r == OMM_G_OFF);
endmodule : omm_gate_cell

// ---- rtl/omm_ctrl.sv ----
// Purpose: Output mute gating and divider margin enables with register file
// Assumes: Source-valid and clock-level inputs arrive from other domains
// Notes:   NVM load copies an image into the registers on a one-cycle strobe
`timescale 1ns/1ps
module omm_ctrl (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [omm_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [omm_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [omm_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [omm_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          nvm_load,
  input  wire logic [7:0]                    nvm_chan_mute,
  input  wire logic [1:0]                    nvm_stat_mute,
  input  wire logic [5:0]                    nvm_div_dly,
  input  wire logic                          src_valid,
  input  wire logic [omm_pkg::NUM_CH-1:0]    chan_clk_lvl,
  input  wire logic [omm_pkg::NUM_STAT-1:0]  stat_clk_lvl,
  input  wire logic [omm_pkg::NUM_STAT-1:0]  stat_is_clock,
  input  wire logic [omm_pkg::NUM_DIV*8-1:0] div_value,
  output omm_pkg::omm_gate_t                 gate_off,
  output logic [omm_pkg::NUM_DIV-1:0]        div_margin_en
);
  import omm_pkg::*;

  logic [7:0]          chan_mute_r;
  logic [1:0]          stat_mute_r;
  logic [5:0]          div_dly_r;
  logic [DATA_W-1:0]   rdata_r;
  logic [1:0]          rresp_r;
  logic                rvalid_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                aw_held_r;
  logic                w_held_r;
  logic [ADDR_W-1:0]   awaddr_r;
  logic [DATA_W-1:0]   wdata_r;
  logic [3:0]          wstrb_r;
  logic                wr_fire;
  logic                wr_hit;
  logic [ADDR_W-1:0]   wr_addr;
  logic [DATA_W-1:0]   wr_data;
  logic [3:0]          wr_strb;
  logic                rd_fire;

  // Two-flop synchronisers; first stage read only by the second
  logic                valid_s1_r;
  logic                valid_s2_r;
  logic [NUM_CH-1:0]   chan_s1_r;
  logic [NUM_CH-1:0]   chan_s2_r;
  logic [NUM_STAT-1:0] stat_s1_r;
  logic [NUM_STAT-1:0] stat_s2_r;
  logic [NUM_STAT-1:0] mode_s1_r;
  logic [NUM_STAT-1:0] mode_s2_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid_s1_r <= 1'b0;
      valid_s2_r <= 1'b0;
      chan_s1_r  <= '0;
      chan_s2_r  <= '0;
      stat_s1_r  <= '0;
      stat_s2_r  <= '0;
      mode_s1_r  <= '0;
      mode_s2_r  <= '0;
    end else begin
      valid_s1_r <= src_valid;
      valid_s2_r <= valid_s1_r;
      chan_s1_r  <= chan_clk_lvl;
      chan_s2_r  <= chan_s1_r;
      stat_s1_r  <= stat_clk_lvl;
      stat_s2_r  <= stat_s1_r;
      mode_s1_r  <= stat_is_clock;
      mode_s2_r  <= mode_s1_r;
    end
  end

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;

  // A firing write consumes both halves; holding one would replay it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end
  end

  assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
  assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  assign wr_fire = !bvalid_r && (aw_held_r || s_axi_awvalid) && (w_held_r || s_axi_wvalid);
  assign wr_hit  = (wr_addr == ADDR_CHAN_MUTE) || (wr_addr == ADDR_STAT_MUTE)
                || (wr_addr == ADDR_DIV_DLY) || (wr_addr == ADDR_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // Registers; NVM load wins over a bus write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_mute_r <= RST_CHAN_MUTE;
    end else if (nvm_load) begin
      chan_mute_r <= nvm_chan_mute;
    end else if (wr_fire && wr_addr == ADDR_CHAN_MUTE && wr_strb[0]) begin
      chan_mute_r <= wr_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_mute_r <= RST_STAT_MUTE;
    end else if (nvm_load) begin
      stat_mute_r <= nvm_stat_mute;
    end else if (wr_fire && wr_addr == ADDR_STAT_MUTE && wr_strb[0]) begin
      stat_mute_r <= wr_data[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_dly_r <= RST_DIV_DLY;
    end else if (nvm_load) begin
      div_dly_r <= nvm_div_dly;
    end else if (wr_fire && wr_addr == ADDR_DIV_DLY && wr_strb[0]) begin
      div_dly_r <= wr_data[5:0];
    end
  end

  // Read channel: one read at a time, reserved bits read zero
  assign s_axi_arready = !rvalid_r;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CHAN_MUTE: rdata_r <= {24'h0, chan_mute_r};
        ADDR_STAT_MUTE: rdata_r <= {30'h0, stat_mute_r};
        ADDR_DIV_DLY:   rdata_r <= {26'h0, div_dly_r};
        // Status word is 17 bits wide; the upper 15 read zero
        ADDR_STATUS:    rdata_r <= {15'h0, div_margin_en, gate_off, valid_s2_r};
        default: begin
          rdata_r <= '0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // Mute request: enable bit and lost source decide, plus clock mode for status pins, never the mute level
  logic [NUM_CH-1:0]   chan_want;
  logic [NUM_STAT-1:0] stat_want;
  logic [NUM_CH-1:0]   chan_off;
  logic [NUM_STAT-1:0] stat_off;

  assign chan_want = chan_mute_r & {NUM_CH{!valid_s2_r}};
  assign stat_want = stat_mute_r & mode_s2_r & {NUM_STAT{!valid_s2_r}};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
      omm_gate_cell u_gate (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .want_off (chan_want[gi]),
        .clk_low  (!chan_s2_r[gi]),
        .gate_off (chan_off[gi])
      );
    end
    for (gi = 0; gi < NUM_STAT; gi++) begin : g_stat
      omm_gate_cell u_gate (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .want_off (stat_want[gi]),
        .clk_low  (!stat_s2_r[gi]),
        .gate_off (stat_off[gi])
      );
    end
  endgenerate

  // Non-clock status pins never held gated
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_off <= '0;
    end else begin
      gate_off.chan_gate <= chan_off;
      gate_off.stat_gate <= stat_off & mode_s2_r;
    end
  end

  // Margin delay only takes effect above divide-by-eight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_margin_en <= '0;
    end else begin
      for (int i = 0; i < NUM_DIV; i++) begin
        div_margin_en[i] <= div_dly_r[i] && (div_value[i*8 +: 8] > MARGIN_MIN_DIV);
      end
    end
  end

endmodule : omm_ctrl

// ---- testbench/omm_ctrl_props.sv ----
// Purpose: Port-level assertions for the output mute and margin control
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to every omm_ctrl instance
`timescale 1ns/1ps
module omm_ctrl_props (
  input wire logic                          aclk,
  input wire logic                          aresetn,
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic                          s_axi_wvalid,
  input wire logic                          s_axi_wready,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic [omm_pkg::ADDR_W-1:0]    s_axi_araddr,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [omm_pkg::DATA_W-1:0]    s_axi_rdata,
  input wire logic [1:0]                    s_axi_rresp,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready,
  input wire logic                          src_valid,
  input wire logic [omm_pkg::NUM_CH-1:0]    chan_clk_lvl,
  input wire logic [omm_pkg::NUM_STAT-1:0]  stat_clk_lvl,
  input wire logic [omm_pkg::NUM_STAT-1:0]  stat_is_clock,
  input wire logic [omm_pkg::NUM_DIV*8-1:0] div_value,
  input omm_pkg::omm_gate_t                 gate_off,
  input wire logic [omm_pkg::NUM_DIV-1:0]   div_margin_en
);
  import omm_pkg::*;
  logic [NUM_DIV-1:0] gt8;
  always_comb for (int i = 0; i < NUM_DIV; i++) gt8[i] = div_value[i*8+:8] > MARGIN_MIN_DIV;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Eight cycles covers sync, wait, off and output stages
  sequence src_ok_s; (src_valid && chan_clk_lvl == 8'h00) [*8]; endsequence
  sequence s0_free_s; (!stat_is_clock[0] && !stat_clk_lvl[0]) [*8]; endsequence
  sequence s1_free_s; (!stat_is_clock[1] && !stat_clk_lvl[1]) [*8]; endsequence
  chan_release_a: assert property (src_ok_s |-> gate_off.chan_gate == 8'h00)
    else $error("channel gated while source valid");
  stat0_free_a: assert property (s0_free_s |-> !gate_off.stat_gate[0])
    else $error("status pin 0 gated while not a clock");
  stat1_free_a: assert property (s1_free_s |-> !gate_off.stat_gate[1])
    else $error("status pin 1 gated while not a clock");
  margin_div_a: assert property ((div_margin_en & ~$past(gt8)) == 6'h00)
    else $error("margin enabled for small divide");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready
    && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : omm_ctrl_props

bind omm_ctrl omm_ctrl_props i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_valid,
  .chan_clk_lvl, .stat_clk_lvl, .stat_is_clock, .div_value, .gate_off, .div_margin_en);

// ---- testbench/omm_ctrl_bench.sv ----
// Purpose: Register and gating tests for the output mute and margin control
// Assumes: Output clock levels low, except where a high phase is held
// Notes:   Gate waits are fixed since the settle time is a few edges
`timescale 1ns/1ps
module omm_ctrl_bench;
  import omm_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, nvm_load, src_valid, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, nvm_chan_mute, chan_clk_lvl;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, nvm_stat_mute, stat_clk_lvl, stat_is_clock;
  logic [5:0]  nvm_div_dly, div_margin_en;
  logic [47:0] div_value;
  omm_gate_t   gate_off;
  int          errors, tests_run;

  omm_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .nvm_load, .nvm_chan_mute, .nvm_stat_mute, .nvm_div_dly, .src_valid,
    .chan_clk_lvl, .stat_clk_lvl, .stat_is_clock, .div_value, .gate_off, .div_margin_en);

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask : rd

  // Gate path needs sync, wait, off and output stages
  task automatic gchk(input logic [9:0] e);
    repeat (12) @(posedge aclk);
    chk({22'h0, gate_off}, {22'h0, e});
  endtask : gchk

  task automatic wrap_up();
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    repeat (3000) @(posedge aclk);
    errors++;
    wrap_up();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, nvm_load, chan_clk_lvl, stat_clk_lvl} = '0;
    s_axi_wstrb = 4'hF;
    src_valid = 1'b1;
    stat_is_clock = 2'b00;
    {nvm_chan_mute, nvm_stat_mute, nvm_div_dly} = {8'h3C, 2'h1, 6'h21};
    div_value = {8'h09, 8'h08, 8'hFF, 8'h01, 8'h09, 8'h08};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CHAN_MUTE, 32'hFF, RESP_OKAY);
    rd(ADDR_STAT_MUTE, 32'h2, RESP_OKAY);
    rd(ADDR_DIV_DLY, 32'h0, RESP_OKAY);
    wr(ADDR_CHAN_MUTE, 32'hA5, RESP_OKAY);
    rd(ADDR_CHAN_MUTE, 32'hA5, RESP_OKAY);
    // Low byte lane off: write answered but register untouched
    s_axi_wstrb <= 4'h0;
    wr(ADDR_CHAN_MUTE, 32'h00, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(ADDR_CHAN_MUTE, 32'hA5, RESP_OKAY);
    wr(ADDR_STAT_MUTE, 32'hFFFFFFFF, RESP_OKAY);
    rd(ADDR_STAT_MUTE, 32'h3, RESP_OKAY);
    wr(ADDR_DIV_DLY, 32'hFFFFFFFF, RESP_OKAY);
    rd(ADDR_DIV_DLY, 32'h3F, RESP_OKAY);
    wr(8'h00, 32'h1, RESP_SLVERR);
    rd(8'h00, 32'h0, RESP_SLVERR);
    repeat (3) @(posedge aclk);
    chk({26'h0, div_margin_en}, 32'h2A);
    wr(ADDR_DIV_DLY, 32'h17, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk({26'h0, div_margin_en}, 32'h02);
    stat_is_clock <= 2'b10;
    src_valid <= 1'b0;
    gchk(10'h296);
    // Status word is read-only: margin 0x02, gates 0x296, source invalid
    wr(ADDR_STATUS, 32'hFFFFFFFF, RESP_OKAY);
    rd(ADDR_STATUS, 32'h152C, RESP_OKAY);
    stat_is_clock <= 2'b01;
    gchk(10'h295);
    src_valid <= 1'b1;
    gchk(10'h000);
    // Image load replaces all three registers in one strobe
    @(posedge aclk);
    nvm_load <= 1'b1;
    @(posedge aclk);
    nvm_load <= 1'b0;
    rd(ADDR_CHAN_MUTE, 32'h3C, RESP_OKAY);
    rd(ADDR_STAT_MUTE, 32'h1, RESP_OKAY);
    rd(ADDR_DIV_DLY, 32'h21, RESP_OKAY);
    chk({26'h0, div_margin_en}, 32'h20);
    stat_is_clock <= 2'b11;
    {chan_clk_lvl, stat_clk_lvl} <= 10'h3FF;
    src_valid <= 1'b0;
    // Clocks held high: gates must wait for a low phase
    gchk(10'h000);
    {chan_clk_lvl, stat_clk_lvl} <= 10'h000;
    gchk(10'h0F1);
    src_valid <= 1'b1;
    gchk(10'h000);
    wrap_up();
  end
endmodule : omm_ctrl_bench
